// ### test/ccpwm_unit_bench.sv
// ccpwm_unit_bench.sv: self-checking bench for the two-channel pwm unit
// assumes: ccpwm_pkg compiled first, ccpwm_cfg.svh on the include path
`timescale 1ns/1ps
`default_nettype none
`include "ccpwm_cfg.svh"

module ccpwm_unit_bench;
    import ccpwm_pkg::*;

    logic              ref_clk_in;
    logic              arst_n_in;
    logic              sleep_in;
    ccpwm_bus_req_type bus_req;
    logic [7:0]        rdata;
    ccpwm_pin_type     ch1_pin;
    ccpwm_pin_type     pin_a;
    ccpwm_pin_type     pin_b;
    int                fail_count;
    int                check_count;

    ccpwm_unit u_dut (
        .ref_clk_in    (ref_clk_in),
        .arst_n_in     (arst_n_in),
        .sleep_in      (sleep_in),
        .bus_req_in    (bus_req),
        .rdata_out     (rdata),
        .ch1_pin_out   (ch1_pin),
        .alt_pin_a_out (pin_a),
        .alt_pin_b_out (pin_b)
    );

    initial
    begin
        ref_clk_in = 1'h0;
        forever #5 ref_clk_in = ~ref_clk_in;
    end

    task automatic end_sim();
        $display("checks %0d, mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask : end_sim

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
        check_count++;
        if (got !== exp)
        begin
            fail_count++;
            $display("Error at %0t: %s got %h expected %h", $time, what, got, exp);
        end
    endtask : check

    // one-cycle strobes; a gap cycle follows each access
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge ref_clk_in);
        bus_req <= '{addr: a, wdata: d, wr: 1'h1, rd: 1'h0};
        @(posedge ref_clk_in);
        bus_req.wr <= 1'h0;
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        @(posedge ref_clk_in);
        bus_req <= '{addr: a, wdata: 8'h00, wr: 1'h0, rd: 1'h1};
        @(posedge ref_clk_in);
        bus_req.rd <= 1'h0;
        @(negedge ref_clk_in);
        d = rdata;
    endtask : rd

    task automatic rd_chk(input logic [3:0] a, input logic [7:0] e, input string what);
        logic [7:0] d;
        rd(a, d);
        check({8'h00, d}, {8'h00, e}, what);
    endtask : rd_chk

    function automatic logic pin_lvl(input int sel);
        return (sel == 0) ? ch1_pin.out : ((sel == 1) ? pin_a.out : pin_b.out);
    endfunction : pin_lvl

    // pin sampled at falling edges, well away from the launching edge
    task automatic measure(input int sel, output int hi, output int per);
        int n;
        n = 0;
        hi = 0;
        @(negedge ref_clk_in);
        while (pin_lvl(sel) !== 1'h0 && n < 3000)
        begin
            @(negedge ref_clk_in);
            n++;
        end
        while (pin_lvl(sel) !== 1'h1 && n < 3000)
        begin
            @(negedge ref_clk_in);
            n++;
        end
        while (pin_lvl(sel) === 1'h1 && hi < 3000)
        begin
            @(negedge ref_clk_in);
            hi++;
        end
        per = hi;
        while (pin_lvl(sel) !== 1'h1 && per < 3000)
        begin
            @(negedge ref_clk_in);
            per++;
        end
    endtask : measure

    task automatic count_high(input int sel, input int len, output int c);
        c = 0;
        repeat (len)
        begin
            @(negedge ref_clk_in);
            c += (pin_lvl(sel) === 1'h1) ? 1 : 0;
        end
    endtask : count_high

    // postscaler bits all set on purpose: they must not alter the period
    task automatic setup_pwm(input logic [7:0] lim, input logic [1:0] ps, input logic [9:0] d);
        wr(`CCPWM_ADDR_PER_LIMIT, lim);
        wr(`CCPWM_ADDR_DUTY1_UP, d[9:2]);
        wr(`CCPWM_ADDR_CH1_CTRL, {2'h0, d[1:0], 4'hC});
        wr(`CCPWM_ADDR_TMR_CTRL, {1'h0, 4'hF, 1'h1, ps});
    endtask : setup_pwm

    initial
    begin
        repeat (60000) @(posedge ref_clk_in);
        fail_count++;
        $display("Error at %0t: watchdog expired", $time);
        end_sim();
    end

    initial
    begin : main
        int         hi;
        int         per;
        int         c;
        logic [7:0] t0;
        logic [7:0] t1;
        int         mult [4] = '{1, 4, 16, 16};
        bus_req     = '0;
        sleep_in    = 1'h0;
        arst_n_in   = 1'h0;
        fail_count  = 0;
        check_count = 0;
        repeat (16) @(posedge ref_clk_in);
        arst_n_in <= 1'h1;
        check({13'h0000, ch1_pin.oe, pin_a.oe, pin_b.oe}, 16'h0000, "oe in reset");
        for (int i = 0; i < 10; i++)
            rd_chk(i[3:0], (i == 6) ? 8'hFF : 8'h00, "reset value");
        rd_chk(4'hF, 8'h00, "unmapped read");
        for (int m = 0; m < 16; m++)
        begin
            wr(`CCPWM_ADDR_CH2_CTRL, {4'h0, m[3:0]});
            repeat (2) @(negedge ref_clk_in);
            check({14'h0000, pin_a.oe, pin_a.out}, {14'h0000, m[3:2] == 2'h3, 1'h0},
                "mode enable");
            check({15'h0000, pin_b.oe}, 16'h0000, "alt b idle");
        end
        wr(`CCPWM_ADDR_CH2_CTRL, 8'hFF);
        rd_chk(`CCPWM_ADDR_CH2_CTRL, 8'h3F, "ctrl mask");
        wr(`CCPWM_ADDR_TMR_CTRL, 8'hFF);
        rd_chk(`CCPWM_ADDR_TMR_CTRL, 8'h7F, "timer ctrl mask");
        wr(`CCPWM_ADDR_CH2_CTRL, 8'h00);
        // each prescale code: two passes so the first settles the phase
        foreach (mult[k])
        begin
            setup_pwm(8'h03, k[1:0], 10'h005);
            repeat (2) measure(0, hi, per);
            check(16'(hi), 16'(5 * mult[k]), "high time");
            check(16'(per), 16'(16 * mult[k]), "period");
            check({15'h0000, ch1_pin.oe}, 16'h0001, "pwm oe");
        end
        setup_pwm(8'h03, 2'h0, 10'h005);
        repeat (2) measure(0, hi, per);
        // new duty written while the pin is high must wait for the period end
        wr(`CCPWM_ADDR_DUTY1_UP, 8'h02);
        wr(`CCPWM_ADDR_CH1_CTRL, 8'h1C);
        repeat (3) @(negedge ref_clk_in);
        check({15'h0000, ch1_pin.out}, 16'h0000, "old duty kept");
        measure(0, hi, per);
        check(16'(hi), 16'h0009, "new duty");
        rd_chk(`CCPWM_ADDR_DUTY1_SHD, 8'h02, "shadow load");
        wr(`CCPWM_ADDR_DUTY1_SHD, 8'h5A);
        rd_chk(`CCPWM_ADDR_DUTY1_SHD, 8'h02, "shadow write");
        wr(`CCPWM_ADDR_DUTY1_UP, 8'h05);
        wr(`CCPWM_ADDR_CH1_CTRL, 8'h0C);
        count_high(0, 40, c);
        count_high(0, 40, c);
        check(16'(c), 16'h0028, "duty over period");
        wr(`CCPWM_ADDR_DUTY1_UP, 8'h00);
        count_high(0, 40, c);
        count_high(0, 40, c);
        check(16'(c), 16'h0000, "zero duty");
        wr(`CCPWM_ADDR_DUTY2_UP, 8'h01);
        wr(`CCPWM_ADDR_CH2_CTRL, 8'h2C);
        wr(`CCPWM_ADDR_ALT_SEL, 8'h01);
        repeat (2) measure(2, hi, per);
        check(16'(hi), 16'h0006, "alt b duty");
        check(16'(per), 16'h0010, "alt b period");
        check({14'h0000, pin_a.oe, pin_b.oe}, 16'h0001, "alt routing");
        setup_pwm(8'hFF, 2'h0, 10'h201);
        repeat (2) measure(0, hi, per);
        check(16'(hi), 16'h0201, "ten bit duty");
        check(16'(per), 16'h0400, "ten bit period");
        // sleep across the duty match: pin and timer must both hold
        repeat (400) @(negedge ref_clk_in);
        rd(`CCPWM_ADDR_TMR_COUNT, t0);
        @(posedge ref_clk_in);
        sleep_in <= 1'h1;
        count_high(0, 600, c);
        check(16'(c), 16'h0258, "sleep hold pin");
        @(posedge ref_clk_in);
        sleep_in <= 1'h0;
        rd(`CCPWM_ADDR_TMR_COUNT, t1);
        check({15'h0000, (t1 - t0) <= 8'h02}, 16'h0001, "sleep hold timer");
        wr(`CCPWM_ADDR_CH1_CTRL, 8'h00);
        repeat (2) @(negedge ref_clk_in);
        check({14'h0000, ch1_pin.oe, ch1_pin.out}, 16'h0000, "release pin");
        end_sim();
    end

endmodule : ccpwm_unit_bench

`default_nettype wire

// ### verilog/ccpwm_cfg.svh
// ccpwm_cfg.svh: offsets, field positions, reset values and timing counts
// assumes: included by bare name from files under verilog/
`ifndef CCPWM_CFG_SVH
`define CCPWM_CFG_SVH

// register map, one word-wide index per register on the plain port
`define CCPWM_ADDR_CH1_CTRL    4'h0
`define CCPWM_ADDR_CH2_CTRL    4'h1
`define CCPWM_ADDR_DUTY1_UP    4'h2
`define CCPWM_ADDR_DUTY1_SHD   4'h3
`define CCPWM_ADDR_DUTY2_UP    4'h4
`define CCPWM_ADDR_DUTY2_SHD   4'h5
`define CCPWM_ADDR_PER_LIMIT   4'h6
`define CCPWM_ADDR_TMR_CTRL    4'h7
`define CCPWM_ADDR_TMR_COUNT   4'h8
`define CCPWM_ADDR_ALT_SEL     4'h9

// channel control fields
`define CCPWM_CTRL_DLO_MSB     5
`define CCPWM_CTRL_DLO_LSB     4
`define CCPWM_CTRL_MODE_MSB    3
`define CCPWM_CTRL_MODE_LSB    0
`define CCPWM_CTRL_MASK        8'h3F
`define CCPWM_MODE_PWM         4'hC
`define CCPWM_MODE_PWM_MASK    4'hC

// timer control fields
`define CCPWM_TCTL_ON_BIT      2
`define CCPWM_TCTL_PS_MSB      1
`define CCPWM_TCTL_PS_LSB      0
`define CCPWM_TCTL_MASK        8'h7F

// reset values
`define CCPWM_RST_CTRL         8'h00
`define CCPWM_RST_PER_LIMIT    8'hFF
`define CCPWM_RST_TMR_CTRL     8'h00
`define CCPWM_RST_TMR_COUNT    8'h00
`define CCPWM_RST_DUTY         8'h00

// prescale codes and the quarter count of one oscillator period group
`define CCPWM_PS_DIV1          2'b00
`define CCPWM_PS_DIV4          2'b01
`define CCPWM_PS_DIV16_MSB     1
`define CCPWM_QUARTERS         4

`endif

// ### verilog/ccpwm_channel.sv
// ccpwm_channel.sv: one pwm channel, duty double buffer and compare
// assumes: timebase and period tick come from the shared timer in the top
`timescale 1ns/1ps
`default_nettype none
`include "ccpwm_cfg.svh"

module ccpwm_channel
    import ccpwm_pkg::*;
(
    // clock and reset
    input  wire logic                  ref_clk_in,
    input  wire logic                  arst_n_in,
    // control
    input  wire logic                  run_in,
    input  wire logic                  pwm_mode_in,
    input  wire logic                  ctrl_zero_in,
    input  wire logic [9:0]            duty_in,
    // shared time base, the value of the coming cycle
    input  wire logic                  period_tick_in,
    input  wire logic [9:0]            timebase_in,
    // results
    output logic         [7:0]         shadow_out,
    output ccpwm_pkg::ccpwm_pin_type   pin_out
);
    import ccpwm_pkg::*;

    logic [7:0] shadow;
    logic [1:0] low_latch;
    logic       level;
    logic [7:0] next_shadow;
    logic [1:0] next_low_latch;
    logic       next_level;

    always_comb
    begin
        next_shadow    = shadow;
        next_low_latch = low_latch;
        next_level     = level;
        if (ctrl_zero_in)
        begin
            next_level = 1'b0;
        end
        // frozen while asleep: only an all-zero control still clears the pin
        else if (run_in && pwm_mode_in)
        begin
            if (period_tick_in)
            begin
                next_shadow    = duty_in[9:2];  // R7 R9
                next_low_latch = duty_in[1:0];  // R9
                next_level     = (duty_in != 10'h000);  // R4
            end
            // a duty beyond the period never matches, so the pin holds
            else if (timebase_in == {shadow, low_latch})
            begin
                next_level = 1'b0;  // R11 R13
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            shadow    <= `CCPWM_RST_DUTY;
            low_latch <= 2'b00;
            level     <= 1'b0;
        end
        else
        begin
            shadow    <= next_shadow;
            low_latch <= next_low_latch;
            level     <= next_level;
        end
    end

    assign shadow_out  = shadow;
    assign pin_out.out = level;  // R2
    assign pin_out.oe  = pwm_mode_in;  // R16

    chk_clear_on_match: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R11
        (run_in && pwm_mode_in && !ctrl_zero_in && !period_tick_in
         && timebase_in == {shadow, low_latch}) |=> !level)
        else $error("pin not cleared on duty match");

    chk_shadow_load: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R9
        (run_in && pwm_mode_in && !ctrl_zero_in && period_tick_in)
        |=> (shadow == $past(duty_in[9:2]) && low_latch == $past(duty_in[1:0])))
        else $error("duty not copied to shadow on period end");

endmodule : ccpwm_channel
`default_nettype wire

// ### verilog/ccpwm_pkg.sv
// ccpwm_pkg.sv: types shared by the pwm unit files
// assumes: ccpwm_cfg.svh on the include path
package ccpwm_pkg;

    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } ccpwm_bus_req_type;

    typedef struct packed {
        logic out;
        logic oe;
    } ccpwm_pin_type;

endpackage : ccpwm_pkg

// ### verilog/ccpwm_unit.sv
// ccpwm_unit.sv: two-channel pwm unit with shared period timer
// assumes: plain register port; pin direction bits live outside this block
`timescale 1ns/1ps
`default_nettype none
`include "ccpwm_cfg.svh"
//
// Summary of operation
// R1 - nothing compares or counts while the sleep input is high.
// R2 - pwm mode drives a pulse waveform of up to ten bits.
// R3 - period equals (limit+1) times four oscillator periods times prescale.
// R4 - after timer hits limit: clear timer, set pin unless duty zero, load shadow.
// R5 - no postscaler takes part in the pwm period.
// R6 - duty is upper byte with control bits 5:4 as low bits.
// R7 - duty writes take effect only at the end of the period.
// R8 - shadow byte reads back but ignores writes in pwm mode.
// R9 - shadow byte plus two-bit latch double-buffer the duty.
// R10 - time base is timer with quarter count or prescaler low bits.
// R11 - pin goes low when time base equals buffered duty.
// R12 - resolution is log2 of 4*(limit+1), ten bits at limit 255.
// R13 - duty longer than period leaves the pin unchanged.
// R14 - sleep freezes timer and channel; pin keeps its level.
// R15 - software must set the pin direction to output.
// R16 - an all-zero control register releases the pin.
// R17 - second channel output goes to one of two alternate pins.
// R18 - prescaler divides by one, four or sixteen.
// R19 - reset returns every register to its reset value.
// R20 - any mode field code with bits 3:2 set (4'hC to 4'hF) selects pwm mode.

module ccpwm_unit
    import ccpwm_pkg::*;
(
    // clock and reset
    input  wire logic                        ref_clk_in,
    input  wire logic                        arst_n_in,
    // power state
    input  wire logic                        sleep_in,
    // register port
    input  wire ccpwm_pkg::ccpwm_bus_req_type bus_req_in,
    output logic [7:0]                       rdata_out,
    // pins
    output ccpwm_pkg::ccpwm_pin_type         ch1_pin_out,
    output ccpwm_pkg::ccpwm_pin_type         alt_pin_a_out,
    output ccpwm_pkg::ccpwm_pin_type         alt_pin_b_out
);
    import ccpwm_pkg::*;

    // registers
    logic [7:0] ch_ctrl [2];
    logic [7:0] duty_up [2];
    logic [7:0] period_limit_reg;
    logic [7:0] period_timer_control;
    logic [7:0] period_timer;
    logic       alt_sel;
    logic [3:0] presc;
    logic [7:0] rdata;

    logic [7:0] next_ch_ctrl [2];
    logic [7:0] next_duty_up [2];
    logic [7:0] next_period_limit_reg;
    logic [7:0] next_period_timer_control;
    logic [7:0] next_period_timer;
    logic       next_alt_sel;
    logic [3:0] next_presc;
    logic [7:0] next_rdata;

    logic       run;
    logic       timer_on;
    logic [1:0] ps_code;
    logic       quarter_end;
    logic       period_tick;
    logic [1:0] time_low;
    logic [9:0] timebase;
    logic [7:0] shadow [2];
    logic       pwm_mode [2];
    logic       ctrl_zero [2];
    ccpwm_pin_type ch_pin [2];
    logic [5:0] phase16;
    logic [5:0] next_phase16;
    logic       inc;

    function automatic logic is_pwm(input logic [7:0] ctrl);
        is_pwm = ((ctrl[`CCPWM_CTRL_MODE_MSB:`CCPWM_CTRL_MODE_LSB]
                   & `CCPWM_MODE_PWM_MASK) == `CCPWM_MODE_PWM);  // R20
    endfunction : is_pwm

    // sleep stops the oscillator, modelled as a freeze of all counting
    assign run      = !sleep_in;  // R1 R14
    assign timer_on = period_timer_control[`CCPWM_TCTL_ON_BIT];
    assign ps_code  = period_timer_control[`CCPWM_TCTL_PS_MSB:`CCPWM_TCTL_PS_LSB];

    // quarter count: one timer increment per four oscillator periods at 1:1
    always_comb
    begin
        if (ps_code == `CCPWM_PS_DIV1)
        begin
            quarter_end = (presc[1:0] == 2'(`CCPWM_QUARTERS - 1));  // R3
            time_low    = next_presc[1:0];  // R10
        end
        else if (ps_code == `CCPWM_PS_DIV4)
        begin
            quarter_end = (presc == 4'hF) && presc[1:0] == 2'b11;  // R18
            time_low    = next_presc[3:2];  // R10
        end
        else
        begin
            quarter_end = 1'b0;  // extended below for 1:16
            time_low    = next_phase16[5:4];  // R10
        end
    end

    // 1:16 uses a wider phase; low two time bits come from its top
    always_comb
    begin
        if (ps_code == `CCPWM_PS_DIV1)
        begin
            inc = quarter_end;
        end
        else if (ps_code == `CCPWM_PS_DIV4)
        begin
            inc = (presc == 4'hF);
        end
        else
        begin
            inc = (phase16 == 6'h3F);  // R18
        end
    end
    // no postscaler: period tick is the raw rollover
    assign period_tick = run && timer_on && inc && (period_timer == period_limit_reg);  // R4 R5
    // channels see the coming time base: their pin flop then falls in
    // the cycle the time base reaches the duty, not one cycle late
    assign timebase    = {next_period_timer, time_low};  // R10 R12

    always_comb
    begin
        next_presc   = presc;
        next_phase16 = phase16;
        next_period_timer = period_timer;
        if (run && timer_on)
        begin
            next_presc   = presc + 4'h1;
            next_phase16 = phase16 + 6'h01;
            if (inc)
            begin
                next_period_timer = period_tick ? 8'h00 : period_timer + 8'h01;  // R3 R4
            end
        end
    end

    // register writes and reads
    always_comb
    begin
        next_ch_ctrl[0] = ch_ctrl[0];
        next_ch_ctrl[1] = ch_ctrl[1];
        next_duty_up[0] = duty_up[0];
        next_duty_up[1] = duty_up[1];
        next_period_limit_reg     = period_limit_reg;
        next_period_timer_control = period_timer_control;
        next_alt_sel = alt_sel;
        next_rdata   = 8'h00;
        if (bus_req_in.wr)
        begin
            if (bus_req_in.addr == `CCPWM_ADDR_CH1_CTRL)
                next_ch_ctrl[0] = bus_req_in.wdata & `CCPWM_CTRL_MASK;  // R6
            else if (bus_req_in.addr == `CCPWM_ADDR_CH2_CTRL)
                next_ch_ctrl[1] = bus_req_in.wdata & `CCPWM_CTRL_MASK;
            else if (bus_req_in.addr == `CCPWM_ADDR_DUTY1_UP)
                next_duty_up[0] = bus_req_in.wdata;  // R7
            else if (bus_req_in.addr == `CCPWM_ADDR_DUTY2_UP)
                next_duty_up[1] = bus_req_in.wdata;
            else if (bus_req_in.addr == `CCPWM_ADDR_PER_LIMIT)
                next_period_limit_reg = bus_req_in.wdata;
            else if (bus_req_in.addr == `CCPWM_ADDR_TMR_CTRL)
                next_period_timer_control = bus_req_in.wdata & `CCPWM_TCTL_MASK;
            else if (bus_req_in.addr == `CCPWM_ADDR_ALT_SEL)
                next_alt_sel = bus_req_in.wdata[0];  // R17
            // shadow bytes are read-only here in every mode; R8
        end
        if (bus_req_in.rd)
        begin
            if (bus_req_in.addr == `CCPWM_ADDR_CH1_CTRL)
                next_rdata = ch_ctrl[0];
            else if (bus_req_in.addr == `CCPWM_ADDR_CH2_CTRL)
                next_rdata = ch_ctrl[1];
            else if (bus_req_in.addr == `CCPWM_ADDR_DUTY1_UP)
                next_rdata = duty_up[0];
            else if (bus_req_in.addr == `CCPWM_ADDR_DUTY1_SHD)
                next_rdata = shadow[0];  // R8
            else if (bus_req_in.addr == `CCPWM_ADDR_DUTY2_UP)
                next_rdata = duty_up[1];
            else if (bus_req_in.addr == `CCPWM_ADDR_DUTY2_SHD)
                next_rdata = shadow[1];
            else if (bus_req_in.addr == `CCPWM_ADDR_PER_LIMIT)
                next_rdata = period_limit_reg;
            else if (bus_req_in.addr == `CCPWM_ADDR_TMR_CTRL)
                next_rdata = period_timer_control;
            else if (bus_req_in.addr == `CCPWM_ADDR_TMR_COUNT)
                next_rdata = period_timer;
            else if (bus_req_in.addr == `CCPWM_ADDR_ALT_SEL)
                next_rdata = {7'h00, alt_sel};
            else
                next_rdata = 8'h00;
        end
    end

    always_ff @(posedge ref_clk_in or negedge arst_n_in)
    begin
        if (!arst_n_in)
        begin
            ch_ctrl[0]           <= `CCPWM_RST_CTRL;  // R19
            ch_ctrl[1]           <= `CCPWM_RST_CTRL;
            duty_up[0]           <= `CCPWM_RST_DUTY;
            duty_up[1]           <= `CCPWM_RST_DUTY;
            period_limit_reg     <= `CCPWM_RST_PER_LIMIT;
            period_timer_control <= `CCPWM_RST_TMR_CTRL;
            period_timer         <= `CCPWM_RST_TMR_COUNT;
            alt_sel              <= 1'b0;
            presc                <= 4'h0;
            phase16              <= 6'h00;
            rdata                <= 8'h00;
        end
        else
        begin
            ch_ctrl[0]           <= next_ch_ctrl[0];
            ch_ctrl[1]           <= next_ch_ctrl[1];
            duty_up[0]           <= next_duty_up[0];
            duty_up[1]           <= next_duty_up[1];
            period_limit_reg     <= next_period_limit_reg;
            period_timer_control <= next_period_timer_control;
            period_timer         <= next_period_timer;
            alt_sel              <= next_alt_sel;
            presc                <= next_presc;
            phase16              <= next_phase16;
            rdata                <= next_rdata;
        end
    end

    assign rdata_out = rdata;

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++)
        begin : g_ch
            assign pwm_mode[gi]  = is_pwm(ch_ctrl[gi]);
            assign ctrl_zero[gi] = (ch_ctrl[gi] == 8'h00);
            ccpwm_channel u_ch (
                .ref_clk_in     (ref_clk_in),
                .arst_n_in      (arst_n_in),
                .run_in         (run),
                .pwm_mode_in    (pwm_mode[gi]),
                .ctrl_zero_in   (ctrl_zero[gi]),
                .duty_in        ({duty_up[gi],
                                  ch_ctrl[gi][`CCPWM_CTRL_DLO_MSB:`CCPWM_CTRL_DLO_LSB]}),  // R6
                .period_tick_in (period_tick),
                .timebase_in    (timebase),
                .shadow_out     (shadow[gi]),
                .pin_out        (ch_pin[gi])
            );
        end
    endgenerate

    // the unselected alternate pin is released, never driven
    assign ch1_pin_out       = ch_pin[0];
    assign alt_pin_a_out.out = ch_pin[1].out;
    assign alt_pin_a_out.oe  = ch_pin[1].oe && !alt_sel;  // R17
    assign alt_pin_b_out.out = ch_pin[1].out;
    assign alt_pin_b_out.oe  = ch_pin[1].oe && alt_sel;  // R17

    chk_sleep_freeze: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R14
        sleep_in |=> $stable(period_timer))
        else $error("timer moved during sleep");

    chk_timer_wrap: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R4
        period_tick |=> (period_timer == 8'h00))
        else $error("timer not cleared after period match");

    chk_shadow_ro: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R8
        (bus_req_in.wr && bus_req_in.addr == `CCPWM_ADDR_DUTY1_SHD && !period_tick)
        |=> $stable(shadow[0]))
        else $error("shadow changed by software write");

    chk_pin_release: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R16
        (ch_ctrl[0] == 8'h00) |-> !ch1_pin_out.oe)
        else $error("pin driven with zero control");

    chk_alt_route: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R17
        !(alt_pin_a_out.oe && alt_pin_b_out.oe))
        else $error("both alternate pins driven");

    chk_read_timer: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R19
        (bus_req_in.rd && bus_req_in.addr == `CCPWM_ADDR_TMR_COUNT)
        |=> (rdata_out == $past(period_timer)))
        else $error("timer readback wrong");

    chk_div1_rate: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R3
        (run && timer_on && ps_code == `CCPWM_PS_DIV1 && presc[1:0] == 2'b00
         && period_timer != period_limit_reg)
        ##1 (run && timer_on && ps_code == `CCPWM_PS_DIV1)[*3] |=> $changed(period_timer))
        else $error("timer rate at 1:1 not four clocks");

    // a pin rises only at a period end, and never for a zero duty
    chk_set_on_period: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R4
        (period_tick && pwm_mode[0]
         && {duty_up[0], ch_ctrl[0][`CCPWM_CTRL_DLO_MSB:`CCPWM_CTRL_DLO_LSB]} != 10'h000)
        |=> ch1_pin_out.out)
        else $error("pin not set at period end");

    chk_zero_duty: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R4
        (period_tick && pwm_mode[0]
         && {duty_up[0], ch_ctrl[0][`CCPWM_CTRL_DLO_MSB:`CCPWM_CTRL_DLO_LSB]} == 10'h000)
        |=> !ch1_pin_out.out)
        else $error("pin set with zero duty");

    chk_rise_on_tick: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R4
        $rose(ch1_pin_out.out) |-> $past(period_tick))
        else $error("pin rose away from period end");

    chk_sleep_pin: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R14
        (sleep_in && ch_ctrl[0] != 8'h00) |=> $stable(ch1_pin_out.out))
        else $error("pin moved during sleep");

    chk_shadow_hold: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R7
        !period_tick |=> ($stable(shadow[0]) && $stable(shadow[1])))
        else $error("shadow changed away from period end");

    // the prescaler alone paces the timer; no postscaler enters
    chk_timer_hold: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R3
        !(run && timer_on && inc) |=> $stable(period_timer))
        else $error("timer moved between increments");

    chk_div4_step: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R18
        (run && timer_on && ps_code == `CCPWM_PS_DIV4 && presc == 4'hF
         && period_timer != period_limit_reg)
        |=> (period_timer == $past(period_timer) + 8'h01))
        else $error("timer step at 1:4 wrong");

    chk_div16_step: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R18
        (run && timer_on && ps_code[`CCPWM_PS_DIV16_MSB] && phase16 == 6'h3F
         && period_timer != period_limit_reg)
        |=> (period_timer == $past(period_timer) + 8'h01))
        else $error("timer step at 1:16 wrong");

    chk_alt_release: assert property (@(posedge ref_clk_in) disable iff (!arst_n_in)  // R16
        (ch_ctrl[1] == 8'h00) |-> !(alt_pin_a_out.oe || alt_pin_b_out.oe))
        else $error("alternate pin driven with zero control");

endmodule : ccpwm_unit
`default_nettype wire
